//--- rtl/sgi_pcs_events.sv
/*
 * Event flags, masks, interrupt, transmit-state report and the exit
 * decision of the auto-negotiation acknowledge state of an SGMII PCS.
 * Assumes the sync, link, page and transmit-state inputs come from logic
 * on clk_i, while the signal loss input arrives from a pin.
 */
`timescale 1ns/1ns
module sgi_pcs_events
  import sgi_pkg::*;
#(
  parameter int ACK_TIMER_CYCLES = 1000
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // Register port.
  input  wire sgi_bus_req_t      bus_i,
  output logic [DATA_W-1:0]      rdata_o,
  // Line and PCS status inputs.
  input  wire logic              signal_loss_i,
  input  wire logic              sync_ok_i,
  input  wire logic              link_ok_i,
  input  wire sgi_tx_state_t     tx_state_i,
  // Auto-negotiation page events.
  input  wire logic              page_done_i,
  input  wire logic              page_is_next_i,
  // Outputs to the negotiation logic and the system.
  output sgi_an_state_t          an_state_o,
  output logic [DATA_W-1:0]      ability_word_o,
  output logic                   irq_o
);

  // ===========================================================
  // Elaboration checks
  // ===========================================================
  // The acknowledge timer must fit its counter and last one cycle at least.
  if (ACK_TIMER_CYCLES < 1 || ACK_TIMER_CYCLES >= (1 << TIMER_W)) begin : g_chk
    $error("ACK_TIMER_CYCLES out of range");
  end

  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(ACK_TIMER_CYCLES - 1);
  localparam logic [TIMER_W-1:0] TIMER_ONE  = TIMER_W'(1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;

  // ===========================================================
  // Address decode
  // ===========================================================
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, IDX_SHIFT};
  endfunction

  sgi_state_t st_reg;
  sgi_state_t st_next;

  logic hit_flags;
  logic hit_masks;
  logic hit_tx;
  logic hit_abil;
  logic hit_sync;

  // Strobes select one register each; other addresses fall through.
  assign hit_flags = bus_i.addr == byte_addr(IDX_FLAGS);
  assign hit_masks = bus_i.addr == byte_addr(IDX_MASKS);
  assign hit_tx    = bus_i.addr == byte_addr(IDX_TXSTATE);
  assign hit_abil  = bus_i.addr == byte_addr(IDX_ABILITY);
  assign hit_sync  = bus_i.addr == byte_addr(IDX_SYNC);

  // ===========================================================
  // Next-state logic
  // ===========================================================
  // One combinational pass computes the whole next state record, so that
  // the interrupt can be registered from the same values that the flags
  // and masks take on this edge; read data come from the current flags.
  always_comb begin
    logic [EVT_W-1:0] set_v;
    logic [EVT_W-1:0] clr_v;
    logic             los_stable;
    logic             abil_wr;
    set_v      = '0;
    clr_v      = '0;
    los_stable = 1'b0;
    abil_wr    = 1'b0;
    st_next    = st_reg;

    // The pin passes three flops; only agreement of the last two counts,
    // which filters a single-cycle glitch at the cost of one more cycle.
    st_next.los_sync = {st_reg.los_sync[1:0], signal_loss_i};
    los_stable = st_reg.los_sync[1] == st_reg.los_sync[2];
    if (los_stable) begin
      st_next.los_level = st_reg.los_sync[2];
    end

    // Previous levels for change detection. Until primed, the first sample
    // after reset only seeds them, so a line already up raises no flag.
    st_next.sync_prev = sync_ok_i;
    st_next.link_prev = link_ok_i;
    st_next.primed    = st_reg.primed | (los_stable & st_reg.los_sync[2] == st_reg.los_level)
                        | st_reg.primed;
    if (!st_reg.primed) begin
      st_next.primed    = los_stable;
      st_next.los_level = st_reg.los_sync[2];
    end

    if (st_reg.primed) begin
      set_v[BIT_LOSS] = los_stable && (st_reg.los_sync[2] != st_reg.los_level);
      set_v[BIT_SYNC] = sync_ok_i != st_reg.sync_prev;
      set_v[BIT_LINK] = link_ok_i != st_reg.link_prev;
    end

    // Page completion puts the negotiation in the acknowledge state; the
    // flag names which page finished.
    if (page_done_i) begin
      set_v[BIT_NP] = page_is_next_i;
      set_v[BIT_BP] = !page_is_next_i;
    end

    // Register writes.
    if (bus_i.wr && hit_flags) begin
      clr_v = bus_i.wdata[EVT_W-1:0];
    end
    if (bus_i.wr && hit_masks) begin
      st_next.masks = bus_i.wdata[EVT_W-1:0];
    end
    if (bus_i.wr && hit_abil) begin
      st_next.ability = bus_i.wdata;
      abil_wr = 1'b1;
    end

    // A new event in the cycle of its clear is kept: set wins over clear.
    st_next.flags = (st_reg.flags & ~clr_v) | set_v;

    // Status mirrors.
    st_next.tx_code = tx_state_i;
    st_next.sync_ok = sync_ok_i;

    // Acknowledge-state exit. Software has until the timer runs out to
    // write a fresh ability word with the next page bit; the choice is
    // made at expiry, so a later rewrite within the window still counts.
    case (st_reg.an_state)
      SGI_AN_ACK: begin
        if (abil_wr) begin
          st_next.fresh_np = bus_i.wdata[ABIL_NP_BIT];
        end
        if (st_reg.timer == TIMER_LAST) begin
          st_next.timer = TIMER_ZERO;
          if (abil_wr ? bus_i.wdata[ABIL_NP_BIT] : st_reg.fresh_np) begin
            st_next.an_state = SGI_AN_NP_WAIT;
          end else begin
            st_next.an_state = SGI_AN_IDLE_DET;
          end
        end else begin
          st_next.timer = st_reg.timer + TIMER_ONE;
        end
      end
      SGI_AN_OTHER,
      SGI_AN_NP_WAIT,
      SGI_AN_IDLE_DET: begin
        st_next.timer    = TIMER_ZERO;
        st_next.fresh_np = 1'b0;
      end
      default: begin
        st_next.an_state = SGI_AN_OTHER;
        st_next.timer    = TIMER_ZERO;
        st_next.fresh_np = 1'b0;
      end
    endcase

    // A completed page always restarts the acknowledge window.
    if (page_done_i) begin
      st_next.an_state = SGI_AN_ACK;
      st_next.timer    = TIMER_ZERO;
      st_next.fresh_np = 1'b0;
    end

    // Read data stand in the cycle after the strobe only; unmapped
    // addresses and reserved bits read as zero.
    st_next.rdata = '0;
    if (bus_i.rd) begin
      if (hit_flags) begin
        st_next.rdata[EVT_W-1:0] = st_reg.flags;
      end else if (hit_masks) begin
        st_next.rdata[EVT_W-1:0] = st_reg.masks;
      end else if (hit_tx) begin
        st_next.rdata[EVT_W-1:0] = st_reg.tx_code;
      end else if (hit_abil) begin
        st_next.rdata = st_reg.ability;
      end else if (hit_sync) begin
        st_next.rdata[0] = st_reg.sync_ok;
      end
    end

    // Registered from the next flags and masks so the line follows them
    // on the same edge.
    st_next.irq = |(st_next.flags & ~st_next.masks);
  end

  // ===========================================================
  // State register
  // ===========================================================
  // Every field takes a constant under reset; masks come up all set so
  // nothing interrupts before software has configured the block.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg.los_sync  <= 3'h0;
      st_reg.los_level <= 1'b0;
      st_reg.sync_prev <= 1'b0;
      st_reg.link_prev <= 1'b0;
      st_reg.primed    <= 1'b0;
      st_reg.flags     <= FLAG_RESET;
      st_reg.masks     <= MASK_RESET;
      st_reg.ability   <= ABIL_RESET;
      st_reg.tx_code   <= SGI_TX_RESET;
      st_reg.sync_ok   <= 1'b0;
      st_reg.an_state  <= SGI_AN_OTHER;
      st_reg.fresh_np  <= 1'b0;
      st_reg.timer     <= TIMER_ZERO;
      st_reg.rdata     <= 16'h0000;
      st_reg.irq       <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ===========================================================
  // Outputs
  // ===========================================================
  // All outputs are fields of the state register.
  assign rdata_o        = st_reg.rdata;
  assign an_state_o     = st_reg.an_state;
  assign ability_word_o = st_reg.ability;
  assign irq_o          = st_reg.irq;

endmodule

//--- rtl/sgi_pkg.sv
/*
 * Constants, types and the state record of the SGMII PCS event and
 * transmit-state block.
 * Assumes one core clock and a 16-bit register port in which a register
 * index is turned into a byte address by a shift of two.
 */
// Contract
// - Flag signal loss input level change
// - Flag sync status change
// - Flag link good/failed toggle
// - Flag next page done in ack state
// - Flag base page done in ack state
// - Fresh NP word before timeout picks next page
// - Writing one clears a flag, zero keeps
// - Five mask bits, one masks, reset set
// - Transmit state codes zero to four
// - Transmit state codes five to nine
// - Transmit state codes ten to twelve
// - Transmit state codes thirteen to sixteen
// - Sync status reads one when synchronised
package sgi_pkg;

  // ===========================================================
  // Register port and map
  // ===========================================================
  localparam int          ADDR_W      = 18;
  localparam int          DATA_W      = 16;
  localparam logic [15:0] IDX_FLAGS   = 16'hD30B;
  localparam logic [15:0] IDX_MASKS   = 16'hD30C;
  localparam logic [15:0] IDX_TXSTATE = 16'hD30D;
  localparam logic [15:0] IDX_ABILITY = 16'hD320;
  localparam logic [15:0] IDX_SYNC    = 16'hD321;
  localparam logic [1:0]  IDX_SHIFT   = 2'h0;

  // ===========================================================
  // Field layout and reset values
  // ===========================================================
  localparam int          EVT_W        = 5;
  localparam int          BIT_LOSS     = 4;
  localparam int          BIT_SYNC     = 3;
  localparam int          BIT_LINK     = 2;
  localparam int          BIT_NP       = 1;
  localparam int          BIT_BP       = 0;
  localparam int          ABIL_NP_BIT  = 15;
  localparam logic [4:0]  FLAG_RESET   = 5'h00;
  localparam logic [4:0]  MASK_RESET   = 5'h1F;
  localparam logic [15:0] ABIL_RESET   = 16'h0000;
  localparam int          TIMER_W      = 16;

  // ===========================================================
  // Types
  // ===========================================================
  typedef enum logic [4:0] {
    SGI_TX_RESET      = 5'b00000,
    SGI_TX_TEST_CHECK = 5'b00001,
    SGI_TX_CONFIG     = 5'b00010,
    SGI_TX_IDLE       = 5'b00011,
    SGI_TX_DATA_IND   = 5'b00100,
    SGI_TX_SOP        = 5'b00101,
    SGI_TX_DATA       = 5'b00110,
    SGI_TX_EOP_NOEXT  = 5'b00111,
    SGI_TX_EOP_EVEN   = 5'b01000,
    SGI_TX_ALIGN_EVEN = 5'b01001,
    SGI_TX_EXT_ODD    = 5'b01010,
    SGI_TX_EXT_BY_1   = 5'b01011,
    SGI_TX_EXT_ERR    = 5'b01100,
    SGI_TX_ERR_ALIGN  = 5'b01101,
    SGI_TX_ERR_START  = 5'b01110,
    SGI_TX_ERR_DATA   = 5'b01111,
    SGI_TX_FALSE_CAR  = 5'b10000
  } sgi_tx_state_t;

  typedef enum logic [1:0] {
    SGI_AN_OTHER    = 2'b00,
    SGI_AN_ACK      = 2'b01,
    SGI_AN_NP_WAIT  = 2'b10,
    SGI_AN_IDLE_DET = 2'b11
  } sgi_an_state_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sgi_bus_req_t;

  typedef struct packed {
    logic [2:0]         los_sync;
    logic               los_level;
    logic               sync_prev;
    logic               link_prev;
    logic               primed;
    logic [EVT_W-1:0]   flags;
    logic [EVT_W-1:0]   masks;
    logic [DATA_W-1:0]  ability;
    sgi_tx_state_t      tx_code;
    logic               sync_ok;
    sgi_an_state_t      an_state;
    logic               fresh_np;
    logic [TIMER_W-1:0] timer;
    logic [DATA_W-1:0]  rdata;
    logic               irq;
  } sgi_state_t;

endpackage

//--- testbench/sgi_pcs_events_chk.sv
/*
 * Port checker for the PCS event block: read timing, state reports, ack exit, interrupt.
 * Assumes it is bound to sgi_pcs_events and that the mask is written only over bus_i.
 */
`timescale 1ns/1ns
module sgi_pcs_events_chk
  import sgi_pkg::*;
#(
  parameter int ACK_TIMER_CYCLES = 1000
) (
  // Clock, reset and register port.
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire sgi_bus_req_t      bus_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // Status inputs and outputs.
  input wire logic              signal_loss_i,
  input wire logic              sync_ok_i,
  input wire logic              link_ok_i,
  input wire sgi_tx_state_t     tx_state_i,
  input wire logic              page_done_i,
  input wire logic              page_is_next_i,
  input wire sgi_an_state_t     an_state_o,
  input wire logic [DATA_W-1:0] ability_word_o,
  input wire logic              irq_o
);
  localparam logic [17:0] A_MSK = {IDX_MASKS, 2'h0};
  localparam logic [17:0] A_TX  = {IDX_TXSTATE, 2'h0};
  localparam logic [17:0] A_AB  = {IDX_ABILITY, 2'h0};
  logic [4:0] mask_reg;
  int         dwell_reg;
  logic       up_reg;
  // ==========================================================
  // Helper mirror of the mask; up_reg skips the seeding sample.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_reg <= MASK_RESET;
      dwell_reg <= 0;
      up_reg <= 1'b0;
    end else begin
      up_reg <= 1'b1;
      if (bus_i.wr && bus_i.addr == A_MSK) begin
        mask_reg <= bus_i.wdata[4:0];
      end
      dwell_reg <= (page_done_i || an_state_o != SGI_AN_ACK) ? 0 : dwell_reg + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_rdata_idle_zero: assert property (
    !$past(bus_i.rd) |-> rdata_o == '0) else $error("read data not zero when idle");
  a_tx_code_read: assert property (
    (bus_i.rd && bus_i.addr == A_TX && $stable(tx_state_i))
    |=> rdata_o == {11'h000, $past(tx_state_i)}) else $error("transmit code read wrong");
  a_ack_entry: assert property (
    page_done_i |=> an_state_o == SGI_AN_ACK) else $error("ack state not entered");
  a_ack_dwell_exact: assert property (
    ($past(an_state_o) == SGI_AN_ACK && an_state_o != SGI_AN_ACK)
    |-> dwell_reg == ACK_TIMER_CYCLES) else $error("ack window length wrong");
  a_ack_exit_target: assert property (
    ($past(an_state_o) == SGI_AN_ACK && an_state_o != SGI_AN_ACK)
    |-> an_state_o inside {SGI_AN_NP_WAIT, SGI_AN_IDLE_DET}) else $error("bad ack exit");
  a_mask_silences: assert property (
    (bus_i.wr && bus_i.addr == A_MSK && bus_i.wdata[4:0] == 5'h1F) |=> !irq_o)
    else $error("irq while all masked");
  a_ability_store: assert property (
    (bus_i.wr && bus_i.addr == A_AB) |=> ability_word_o == $past(bus_i.wdata))
    else $error("ability word not stored");
  a_status_event_irq: assert property (
    up_reg && (($changed(link_ok_i) && !mask_reg[BIT_LINK])
    || ($changed(sync_ok_i) && !mask_reg[BIT_SYNC])) |=> irq_o) else $error("no irq on change");
  a_page_event_irq: assert property (
    (page_done_i && !mask_reg[page_is_next_i ? BIT_NP : BIT_BP]) |=> irq_o)
    else $error("no irq on page");
  c_np_wait: cover property (an_state_o == SGI_AN_NP_WAIT);
  c_idle_det: cover property (an_state_o == SGI_AN_IDLE_DET);
  c_irq_rise: cover property ($rose(irq_o));
endmodule
bind sgi_pcs_events sgi_pcs_events_chk #(.ACK_TIMER_CYCLES(ACK_TIMER_CYCLES)) sgi_chk_inst (
  .clk_i, .resetn_i, .bus_i, .rdata_o, .signal_loss_i, .sync_ok_i, .link_ok_i, .tx_state_i,
  .page_done_i, .page_is_next_i, .an_state_o, .ability_word_o, .irq_o);

//--- testbench/sgi_line_model.sv
/*
 * Far-side model: the line and PCS state machines that feed the event block.
 * Assumes the bench asks for level flips and page pulses on clk_i.
 */
`timescale 1ns/1ns
module sgi_line_model
  import sgi_pkg::*;
(
  // Clock, reset and bench commands.
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic [2:0]    flip_i,
  input  wire logic          page_i,
  input  wire logic          next_i,
  input  wire sgi_tx_state_t code_i,
  // Levels toward the block.
  output logic               signal_loss_o,
  output logic               sync_ok_o,
  output logic               link_ok_o,
  output sgi_tx_state_t      tx_state_o,
  output logic               page_done_o,
  output logic               page_is_next_o
);
  // Levels only change on a flip, so each flip is exactly one event edge.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {signal_loss_o, sync_ok_o, link_ok_o} <= 3'h0;
      tx_state_o <= SGI_TX_RESET;
      page_done_o <= 1'b0;
      page_is_next_o <= 1'b0;
    end else begin
      {signal_loss_o, sync_ok_o, link_ok_o} <= {signal_loss_o, sync_ok_o, link_ok_o} ^ flip_i;
      tx_state_o <= code_i;
      page_done_o <= page_i;
      page_is_next_o <= next_i;
    end
  end
endmodule

//--- testbench/testbench.sv
/*
 * Self-checking bench for sgi_pcs_events with the line model on its far side.
 * Assumes a short ack window of 8 cycles.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import sgi_pkg::*;
  localparam int ACK = 8;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  sgi_bus_req_t bus = '0;
  logic [2:0] flip = 3'h0;
  logic page = 1'b0;
  logic nxt = 1'b0;
  sgi_tx_state_t code = SGI_TX_RESET;
  logic los, syn, lnk, pdone, pnext, irq_o;
  sgi_tx_state_t tx;
  sgi_an_state_t an_state_o;
  logic [15:0] rdata_o;
  logic [15:0] abil;
  int fails = 0;
  int compares = 0;
  int n;
  always #2 clk_i = ~clk_i;
  sgi_line_model sgi_line_model_inst (.clk_i, .resetn_i, .flip_i(flip), .page_i(page),
    .next_i(nxt), .code_i(code), .signal_loss_o(los), .sync_ok_o(syn), .link_ok_o(lnk),
    .tx_state_o(tx), .page_done_o(pdone), .page_is_next_o(pnext));
  sgi_pcs_events #(.ACK_TIMER_CYCLES(ACK)) sgi_pcs_events_inst (.clk_i, .resetn_i,
    .bus_i(bus), .rdata_o, .signal_loss_i(los), .sync_ok_i(syn), .link_ok_i(lnk),
    .tx_state_i(tx), .page_done_i(pdone), .page_is_next_i(pnext), .an_state_o,
    .ability_word_o(abil), .irq_o);
  // ==========================================================
  // Bus and stimulus helpers.
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    bus.wr <= 1'b1;
    bus.addr <= {idx, 2'h0};
    bus.wdata <= d;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look just after that edge.
  task automatic rd(input logic [15:0] idx, input logic [15:0] e);
    @(posedge clk_i);
    bus.rd <= 1'b1;
    bus.addr <= {idx, 2'h0};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask
  task automatic pulse_flip(input int k);
    @(posedge clk_i);
    flip[k] <= 1'b1;
    @(posedge clk_i);
    flip <= 3'h0;
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_reset;
    rd(IDX_FLAGS, 16'h0000);
    rd(IDX_MASKS, 16'h001F);
    rd(IDX_TXSTATE, 16'h0000);
    rd(16'h0000, 16'h0000);
    `CHK(irq_o, 1'b0)
    $display("test reset done");
  endtask
  task automatic t_codes;
    for (int i = 0; i < 17; i++) begin
      @(posedge clk_i);
      code <= sgi_tx_state_t'(5'(i));
      tick(3);
      rd(IDX_TXSTATE, 16'(i));
    end
    $display("test codes done");
  endtask
  // Flip link, sync, then loss; a zero write must keep each flag, a one clears it.
  task automatic t_events;
    wr(IDX_MASKS, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      pulse_flip(k);
      tick(8);
      rd(IDX_FLAGS, 16'(1 << (k + 2)));
      `CHK(irq_o, 1'b1)
      if (k == 1) rd(IDX_SYNC, 16'h0001);
      wr(IDX_FLAGS, 16'h0000);
      rd(IDX_FLAGS, 16'(1 << (k + 2)));
      wr(IDX_FLAGS, 16'(1 << (k + 2)));
      rd(IDX_FLAGS, 16'h0000);
      `CHK(irq_o, 1'b0)
    end
    $display("test events done");
  endtask
  task automatic t_mask;
    wr(IDX_MASKS, 16'h001F);
    pulse_flip(0);
    tick(4);
    `CHK(irq_o, 1'b0)
    wr(IDX_MASKS, 16'h001B);
    rd(IDX_MASKS, 16'h001B);
    `CHK(irq_o, 1'b1)
    wr(IDX_FLAGS, 16'h0004);
    wr(IDX_MASKS, 16'h0000);
    $display("test mask done");
  endtask
  // Base page then next page; only an ability word with bit 15 set leads to the wait state.
  task automatic t_pages;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_i);
      page <= 1'b1;
      nxt <= p[0];
      @(posedge clk_i);
      page <= 1'b0;
      tick(2);
      #1;
      `CHK(an_state_o, SGI_AN_ACK)
      wr(IDX_ABILITY, p ? 16'h8000 : 16'h0001);
      #1;
      `CHK(abil, p ? 16'h8000 : 16'h0001)
      for (n = 0; n < 40 && an_state_o == SGI_AN_ACK; n++) @(posedge clk_i) #1;
      if (n == 40) begin
        fails++;
        tally_and_finish();
      end
      `CHK(an_state_o, p ? SGI_AN_NP_WAIT : SGI_AN_IDLE_DET)
      rd(IDX_FLAGS, p ? 16'h0002 : 16'h0001);
      wr(IDX_FLAGS, 16'h0003);
    end
    $display("test pages done");
  endtask
  initial begin
    tick(3);
    resetn_i <= 1'b1;
    t_reset();
    t_codes();
    t_events();
    t_mask();
    t_pages();
    tally_and_finish();
  end
endmodule
